/* File: common/pfm_pkg.sv */
/*
 Package for the port function multiplexer: sizes, register map,
 reset values, relocation pin placement and bus carrier types.
 Assumes a 32-bit APB master and 16 ports of 16 pins each.
*/
package pfm_pkg;
  // ************************************************************
  // Sizes.
  // ************************************************************
  localparam int NPORT = 16;
  localparam int PW = 16;
  localparam int NPIN = 256;
  localparam int NOUT = 11;
  localparam int NIN = 8;
  localparam int NRELOC = 19;
  localparam int SELW = 2;
  // ************************************************************
  // Register map: group in paddr[11:8], word index in paddr[6:2].
  // ************************************************************
  localparam logic [3:0] GRP_FUNC = 4'h0;
  localparam logic [3:0] GRP_PULL = 4'h1;
  localparam logic [3:0] GRP_DDR = 4'h2;
  localparam logic [3:0] GRP_LVL_IN = 4'h3;
  localparam logic [3:0] GRP_LVL_OUT = 4'h4;
  localparam logic [3:0] GRP_ODRAIN = 4'h5;
  localparam logic [3:0] GRP_SPEC = 4'h6;
  localparam logic [3:0] GRP_RELOC = 4'h7;
  localparam logic [4:0] IDX_ANALOG = 5'h00;
  localparam logic [4:0] IDX_SPECIAL = 5'h01;
  localparam logic [3:0] NO_PULL_PORT = 4'h8;
  // ************************************************************
  // Reset values.
  // ************************************************************
  localparam logic [15:0] FUNC0_RST = 16'h001f;
  localparam logic [15:0] PULL0_RST = 16'h001f;
  localparam logic [15:0] ANALOG_RST = 16'hffff;
  localparam logic [1:0] SPECIAL_RST = 2'h3;
  localparam logic [SELW-1:0] SEL_NONE = 2'h0;
  // ************************************************************
  // Pin placement.
  // ************************************************************
  localparam int TEST_IN_N = 4;
  localparam int RELOC_BASE = 16;
  localparam int NMI_PIN = 20;
  localparam int AN_BASE = 32;
  localparam int OSC_MAIN = 48;
  localparam int OSC_SUB = 50;
  // ************************************************************
  // Bus carriers.
  // ************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pfm_apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pfm_apb_rsp_type;
endpackage : pfm_pkg

/* File: rtl/pfm_port_mux.sv */
/*
 Port function multiplexer: GPIO registers, peripheral relocation,
 fixed-priority output arbitration and deep standby override.
 Assumes APB on pclk; pads resolve pin level from pin_out/pin_oe_n;
 peripherals and deep_standby are synchronous to pclk.
*/
// Register access over APB and the placing of the registers were decided locally.
// Contract
// - Test port pins reset to test function, pulled.
// - Analog pins reset analog, digital input reads 0.
// - Oscillator pins reset oscillator, digital input 0.
// - Other pins reset as input, driver off.
// - Output selections hold no-output during reset.
// - Selection routes each function to one pin.
// - One pin feeds every input selecting it.
// - Input path stays live while pin drives.
// - One output per pin, fixed priority pick.
// - Priority order debug down to subclock output.
// - Inputs are never arbitrated.
// - Special input pin ignores all output selections.
// - Interrupt pin special-input status is build option.
// - Every output field has a no-output code.
// - Deep standby forces all pins to GPIO; cut analog and oscillator pins stay undriven.
// - Per-port select, direction, levels, open-drain; pull-ups on every port but port 8.
// - Nineteen relocation registers plus analog, special select.
// - Function bit 0 GPIO, 1 peripheral.
// - Direction bit 1 drives GPIO pin.
// - Level register reads pin, analog reads 0.
// - Output level bit sets GPIO driven level.
module pfm_port_mux #(
  parameter bit NMI_SPECIAL = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pfm_pkg::pfm_apb_req_type apb_req,
  output pfm_pkg::pfm_apb_rsp_type apb_rsp,
  input wire logic deep_standby,
  input wire logic [pfm_pkg::NPIN-1:0] pin_in,
  output logic [pfm_pkg::NPIN-1:0] pin_out,
  output logic [pfm_pkg::NPIN-1:0] pin_oe_n,
  output logic [pfm_pkg::NPIN-1:0] pin_pullup,
  input wire logic [pfm_pkg::NOUT-1:0] periph_out,
  input wire logic [pfm_pkg::NOUT-1:0] periph_oe,
  output logic [pfm_pkg::NIN-1:0] periph_in
);
  import pfm_pkg::*;

  // ************************************************************
  // Register state.
  // ************************************************************
  logic [PW-1:0] port_function_select_ff [NPORT];
  logic [PW-1:0] pullup_enable_ff [NPORT];
  logic [PW-1:0] ddr_ff [NPORT];
  logic [PW-1:0] pin_level_out_ff [NPORT];
  logic [PW-1:0] pseudo_open_drain_select_ff [NPORT];
  logic [SELW-1:0] extended_function_select_ff [NRELOC];
  logic [PW-1:0] analog_input_select_ff;
  logic [1:0] special_port_select_ff;
  logic [PW-1:0] nxt_port_function_select [NPORT];
  logic [PW-1:0] nxt_pullup_enable [NPORT];
  logic [PW-1:0] nxt_ddr [NPORT];
  logic [PW-1:0] nxt_pin_level_out [NPORT];
  logic [PW-1:0] nxt_pseudo_open_drain_select [NPORT];
  logic [SELW-1:0] nxt_extended_function_select [NRELOC];
  logic [PW-1:0] nxt_analog_input_select;
  logic [1:0] nxt_special_port_select;
  pfm_apb_rsp_type rsp_ff;
  pfm_apb_rsp_type nxt_rsp;
  logic [NPIN-1:0] lvl_ff;
  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;

  // ************************************************************
  // APB slave.
  // ************************************************************
  always_comb begin
    logic [3:0] grp;
    logic [4:0] idx;
    logic [3:0] port;
    logic rd_ok;
    logic wr;
    logic [31:0] rd;
    grp = apb_req.paddr[11:8];
    idx = apb_req.paddr[6:2];
    port = idx[3:0];
    rd_ok = 1'b0;
    rd = 32'h0000_0000;
    wr = apb_req.psel & apb_req.penable & rsp_ff.pready & apb_req.pwrite;
    nxt_port_function_select = port_function_select_ff;
    nxt_pullup_enable = pullup_enable_ff;
    nxt_ddr = ddr_ff;
    nxt_pin_level_out = pin_level_out_ff;
    nxt_pseudo_open_drain_select = pseudo_open_drain_select_ff;
    nxt_extended_function_select = extended_function_select_ff;
    nxt_analog_input_select = analog_input_select_ff;
    nxt_special_port_select = special_port_select_ff;
    if (apb_req.paddr[31:12] == 20'h00000 && apb_req.paddr[1:0] == 2'h0 &&
        apb_req.paddr[7] == 1'b0) begin
      case (grp)
        GRP_FUNC: begin
          rd_ok = ~idx[4];
          rd[PW-1:0] = port_function_select_ff[port];
          if (wr && rd_ok) nxt_port_function_select[port] = apb_req.pwdata[PW-1:0];
        end
        GRP_PULL: begin
          rd_ok = ~idx[4] && port != NO_PULL_PORT;
          rd[PW-1:0] = pullup_enable_ff[port];
          if (wr && rd_ok) nxt_pullup_enable[port] = apb_req.pwdata[PW-1:0];
        end
        GRP_DDR: begin
          rd_ok = ~idx[4];
          rd[PW-1:0] = ddr_ff[port];
          if (wr && rd_ok) nxt_ddr[port] = apb_req.pwdata[PW-1:0];
        end
        GRP_LVL_IN: begin
          // Level read, masked pins read zero.
          rd_ok = ~idx[4] & ~apb_req.pwrite;
          rd[PW-1:0] = lvl_ff[{port, 4'h0} +: PW];
        end
        GRP_LVL_OUT: begin
          rd_ok = ~idx[4];
          rd[PW-1:0] = pin_level_out_ff[port];
          if (wr && rd_ok) nxt_pin_level_out[port] = apb_req.pwdata[PW-1:0];
        end
        GRP_ODRAIN: begin
          rd_ok = ~idx[4];
          rd[PW-1:0] = pseudo_open_drain_select_ff[port];
          if (wr && rd_ok) nxt_pseudo_open_drain_select[port] = apb_req.pwdata[PW-1:0];
        end
        GRP_SPEC: begin
          if (idx == IDX_ANALOG) begin
            rd_ok = 1'b1;
            rd[PW-1:0] = analog_input_select_ff;
            if (wr) nxt_analog_input_select = apb_req.pwdata[PW-1:0];
          end else if (idx == IDX_SPECIAL) begin
            rd_ok = 1'b1;
            rd[1:0] = special_port_select_ff;
            if (wr) nxt_special_port_select = apb_req.pwdata[1:0];
          end
        end
        GRP_RELOC: begin
          if (32'(idx) < NRELOC) begin
            rd_ok = 1'b1;
            rd[SELW-1:0] = extended_function_select_ff[idx];
            if (wr) nxt_extended_function_select[idx] = apb_req.pwdata[SELW-1:0];
          end
        end
        default: rd_ok = 1'b0;
      endcase
    end
    // One wait state: data and error are registered on the same edge that raises pready.
    nxt_rsp = rsp_ff;
    if (apb_req.psel && apb_req.penable && !rsp_ff.pready) begin
      nxt_rsp.pready = 1'b1;
      nxt_rsp.pslverr = ~rd_ok;
      nxt_rsp.prdata = rd_ok ? rd : 32'h0000_0000;
    end else begin
      nxt_rsp.pready = 1'b0;
      nxt_rsp.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPORT; i++) begin
        port_function_select_ff[i] <= 16'h0000;
        pullup_enable_ff[i] <= 16'h0000;
        ddr_ff[i] <= 16'h0000;
        pin_level_out_ff[i] <= 16'h0000;
        pseudo_open_drain_select_ff[i] <= 16'h0000;
      end
      // Test port selected and pulled up.
      port_function_select_ff[0] <= FUNC0_RST;
      pullup_enable_ff[0] <= PULL0_RST;
      for (int i = 0; i < NRELOC; i++) begin
        extended_function_select_ff[i] <= SEL_NONE;
      end
      analog_input_select_ff <= ANALOG_RST;
      special_port_select_ff <= SPECIAL_RST;
      rsp_ff <= '0;
    end else begin
      port_function_select_ff <= nxt_port_function_select;
      pullup_enable_ff <= nxt_pullup_enable;
      ddr_ff <= nxt_ddr;
      pin_level_out_ff <= nxt_pin_level_out;
      pseudo_open_drain_select_ff <= nxt_pseudo_open_drain_select;
      extended_function_select_ff <= nxt_extended_function_select;
      analog_input_select_ff <= nxt_analog_input_select;
      special_port_select_ff <= nxt_special_port_select;
      rsp_ff <= nxt_rsp;
    end
  end

  // ************************************************************
  // Per-pin function selection and output arbitration.
  // ************************************************************
  logic [NPIN-1:0] nxt_out;
  logic [NPIN-1:0] nxt_oe_n;
  logic [NPIN-1:0] nxt_pull;
  logic [NPIN-1:0] nxt_lvl;
  logic [NPIN-1:0] out_ff;
  logic [NPIN-1:0] oe_n_ff;
  logic [NPIN-1:0] pull_ff;

  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    localparam int PORT = p / PW;
    localparam int BIT = p % PW;
    logic cut;
    logic spec_in;
    logic hit;
    logic hdat;
    logic periph;
    logic drive;
    logic dval;
    always_comb begin
      cut = 1'b0;
      // The cast keeps the index legal on pins outside the analog port.
      if (p >= AN_BASE && p < AN_BASE + PW) cut = analog_input_select_ff[4'(p - AN_BASE)];
      if (p == OSC_MAIN || p == OSC_MAIN + 1) cut = special_port_select_ff[0];
      if (p == OSC_SUB || p == OSC_SUB + 1) cut = special_port_select_ff[1];
      spec_in = 1'b0;
      if (p < TEST_IN_N) spec_in = port_function_select_ff[0][BIT];
      // Interrupt pin as special input by build option.
      if (NMI_SPECIAL && p == NMI_PIN) spec_in = port_function_select_ff[PORT][BIT];
      // Lowest to highest priority, last active hit wins.
      // Channel 0 is highest, channel 10 lowest.
      hit = 1'b0;
      hdat = 1'b0;
      for (int c = NOUT - 1; c >= 0; c--) begin
        if (extended_function_select_ff[c] != SEL_NONE && periph_oe[c] &&
            RELOC_BASE + c + 32'(extended_function_select_ff[c]) == p) begin
          hit = 1'b1;
          hdat = periph_out[c];
        end
      end
      // Deep standby hands every pin but cut analog and oscillator pins to GPIO.
      periph = port_function_select_ff[PORT][BIT] & ~deep_standby;
      if (cut) begin
        // Analog and oscillator pins never drive.
        drive = 1'b0;
        dval = 1'b0;
      end else if (periph) begin
        drive = hit & ~(spec_in & ~deep_standby);
        dval = hdat;
      end else begin
        drive = ddr_ff[PORT][BIT];
        dval = pin_level_out_ff[PORT][BIT];
      end
      // Pseudo open drain releases the pad instead of driving high.
      if (drive && dval && pseudo_open_drain_select_ff[PORT][BIT]) drive = 1'b0;
      nxt_oe_n[p] = ~drive;
      nxt_out[p] = drive & dval;
      nxt_pull[p] = pullup_enable_ff[PORT][BIT] & ~drive &
                    ~pseudo_open_drain_select_ff[PORT][BIT] & ~cut &
                    (PORT != 32'(NO_PULL_PORT));
      // Level stays live while driving; cut pins read zero.
      nxt_lvl[p] = sync2_ff[p] & ~cut;
    end
  end

  // ************************************************************
  // Peripheral input fan-out.
  // ************************************************************
  logic [NIN-1:0] nxt_pin;
  logic [NIN-1:0] pin_ff;
  always_comb begin
    // Every selected input reads its chosen pin, unselected ones read 0; no arbitration here.
    // Inputs are independent of each other.
    for (int i = 0; i < NIN; i++) begin
      if (extended_function_select_ff[NOUT + i] == SEL_NONE) nxt_pin[i] = 1'b0;
      else nxt_pin[i] = lvl_ff[RELOC_BASE + i + 32'(extended_function_select_ff[NOUT + i])];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      lvl_ff <= '0;
      out_ff <= '0;
      oe_n_ff <= '1;
      pull_ff <= '0;
      pin_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      lvl_ff <= nxt_lvl;
      out_ff <= nxt_out;
      oe_n_ff <= nxt_oe_n;
      pull_ff <= nxt_pull;
      pin_ff <= nxt_pin;
    end
  end

  assign pin_out = out_ff;
  assign pin_oe_n = oe_n_ff;
  assign pin_pullup = pull_ff;
  assign periph_in = pin_ff;
  assign apb_rsp = rsp_ff;
endmodule : pfm_port_mux

/* File: test/pfm_mux_chk.sv */
/* Port checker for the port function multiplexer.
 Assumes it is bound to pfm_port_mux and sees its ports only. */
module pfm_mux_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire pfm_pkg::pfm_apb_req_type apb_req,
  input wire pfm_pkg::pfm_apb_rsp_type apb_rsp,
  input wire logic deep_standby,
  input wire logic [pfm_pkg::NPIN-1:0] pin_out,
  input wire logic [pfm_pkg::NPIN-1:0] pin_oe_n,
  input wire logic [pfm_pkg::NPIN-1:0] pin_pullup
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfm_pkg::*;
  // ********
  // Checks.
  // ********
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_TEST_PULL: assert property ($rose(presetn) |=> pin_pullup[4:0] == 5'h1f)
    else $error("test pins not pulled up after reset");
  AST_RESET_HIZ: assert property ($rose(presetn) |=> &pin_oe_n)
    else $error("pin driven after reset");
  AST_IDLE_LOW: assert property ((pin_out & pin_oe_n) == '0)
    else $error("undriven pin carries data");
  AST_NO_PULL_DRIVEN: assert property ((pin_pullup & ~pin_oe_n) == '0)
    else $error("pull-up on a driven pin");
  AST_NO_PULL_P8: assert property (pin_pullup[143:128] == 16'h0000)
    else $error("pull-up on port 8");
  AST_APB_ANSWER: assert property (apb_req.psel && $rose(apb_req.penable)
    |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("register answer late");
  AST_APB_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready longer than one cycle");
  // A write reaches the pins two edges later, so two idle bus cycles are needed.
  AST_STANDBY_HOLD: assert property (deep_standby && $past(deep_standby)
    && $past(deep_standby, 2) && !$past(apb_req.psel) && !$past(apb_req.psel, 2)
    |-> $stable(pin_out) && $stable(pin_oe_n))
    else $error("peripheral reached a pin in deep standby");
endmodule : pfm_mux_chk
bind pfm_port_mux pfm_mux_chk u_pfm_mux_chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .deep_standby(deep_standby),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup));

/* File: test/pfm_pad_model.sv */
/* Pad model: each pin shows the mux drive when enabled, else the outside level.
 Assumes the outside source always drives, so it beats the weak pull-up. */
module pfm_pad_model (
  input wire logic [pfm_pkg::NPIN-1:0] pin_out,
  input wire logic [pfm_pkg::NPIN-1:0] pin_oe_n,
  input wire logic [pfm_pkg::NPIN-1:0] ext_level,
  output logic [pfm_pkg::NPIN-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfm_pkg::*;
  // ********
  // Pads.
  // ********
  // driven level fed back.
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : pfm_pad_model

/* File: test/port_function_mux_tb.sv */
/* Self-checking bench for the port function multiplexer.
 Assumes the pad model closes the pin loop and the checker is bound. */
module port_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pfm_pkg::*;
  logic pclk, presetn, deep_standby;
  pfm_apb_req_type req;
  pfm_apb_rsp_type rsp;
  logic [NPIN-1:0] ext, pin_in, pin_out, pin_oe_n, pin_pullup;
  logic [NOUT-1:0] periph_out, periph_oe;
  logic [NIN-1:0] periph_in;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] r, x;
  int bad_count, total_checks;
  pfm_port_mux u_pfm_port_mux (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .deep_standby(deep_standby), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in));
  pfm_pad_model u_pfm_pad_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext), .pin_in(pin_in));
  always #20 pclk = ~pclk;
  // ********
  // Tasks.
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] xp);
    total_checks++;
    if (seen !== xp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, xp, seen);
    end
  endtask : check
  task automatic conclude;
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Bit 33 asks for a data compare, bit 32 is the expected error flag.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [33:0] xp);
    int n;
    exp_q.push_back(xp);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      conclude();
    end
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {2'b10, d});
  endtask : rd
  always @(posedge pclk) begin
    if (rsp.pready === 1'b1) begin
      e = exp_q.pop_front();
      check("pslverr", {31'h0, rsp.pslverr}, {31'h0, e[32]});
      if (e[33]) check("prdata", rsp.prdata, e[31:0]);
    end
  end
  // ********
  // Scenarios.
  // ********
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    deep_standby = 1'b0;
    req = '0;
    periph_out = '0;
    periph_oe = '0;
    ext = '1;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(32'h078a));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("pullup", {27'h0, pin_pullup[4:0]}, 32'h1f);
    check("hiz", {31'h0, &pin_oe_n}, 32'h1);
    rd(32'h000, 32'h1f);
    rd(32'h100, 32'h1f);
    rd(32'h600, 32'hffff);
    rd(32'h604, 32'h3);
    rd(32'h308, 32'h0);
    rd(32'h30c, 32'hfff0);
    rd(32'h320, 32'hffff);
    for (int k = 0; k < 19; k++) rd(32'h700 + 4 * k, 32'h0);
    apb(1'b0, 32'h800, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 32'h120, 32'h1, {2'b01, 32'h0});
    apb(1'b1, 32'h74c, 32'h1, {2'b01, 32'h0});
    r = $urandom();
    wr(32'h214, 32'hffff);
    wr(32'h414, {16'h0, r[15:0]});
    repeat (2) @(posedge pclk);
    check("drive", {16'h0, pin_out[95:80]}, {16'h0, r[15:0]});
    check("dir", {16'h0, pin_oe_n[95:80]}, 32'h0);
    rd(32'h314, {16'h0, r[15:0]});
    wr(32'h514, 32'hffff);
    repeat (2) @(posedge pclk);
    check("odrain", {16'h0, pin_oe_n[95:80]}, {16'h0, r[15:0]});
    wr(32'h004, 32'h18);
    wr(32'h700, 32'h3);
    wr(32'h704, 32'h2);
    wr(32'h708, 32'h1);
    wr(32'h70c, 32'h1);
    wr(32'h72c, 32'h3);
    wr(32'h730, 32'h2);
    for (int m = 0; m < 8; m++) begin
      r = $urandom();
      periph_out <= r[10:0];
      periph_oe <= {8'h01, m[2:0]};
      repeat (6) @(posedge pclk);
      x = {31'h0, m[0] ? r[0] : m[1] ? r[1] : m[2] ? r[2] : 1'b1};
      check("arb oe", {31'h0, pin_oe_n[19]}, {31'h0, m == 0});
      check("arb out", {31'h0, pin_out[19]}, (m == 0) ? 32'h0 : x);
      check("special", {31'h0, pin_oe_n[20]}, 32'h1);
      check("fanout", {30'h0, periph_in[1:0]}, {30'h0, x[0], x[0]});
    end
    periph_oe <= 11'h001;
    deep_standby <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      periph_out <= 11'($urandom());
      @(posedge pclk);
    end
    check("standby", {31'h0, pin_oe_n[19]}, 32'h1);
    deep_standby <= 1'b0;
    // channel 0 output cleared before the pin serves as input.
    wr(32'h700, 32'h0);
    ext[19] <= 1'b0;
    repeat (6) @(posedge pclk);
    check("ext in", {30'h0, periph_in[1:0]}, 32'h0);
    conclude();
  end
endmodule : port_function_mux_tb
